// ---- home_coord_pkg.sv ----
`default_nettype none
package home_coord_pkg;

   // Reference state of the mechanical coordinate system.
   typedef enum logic [2:0] {
      MS_UNSET  = 3'b001,
      MS_SET    = 3'b010,
      MS_HOMING = 3'b100
   } mech_st_t;

   // Selector encodings.
   localparam logic SEL_SENSOR = 1'b0;
   localparam logic SEL_MANUAL = 1'b1;

   // Codes on the manual parameter write port.
   localparam logic [3:0] PW_GEAR_DEN   = 4'h0;
   localparam logic [3:0] PW_GEAR_NUM   = 4'h1;
   localparam logic [3:0] PW_DIRECTION  = 4'h2;
   localparam logic [3:0] PW_GEAR_RATIO = 4'h3;
   localparam logic [3:0] PW_WRAP_EN    = 4'h4;
   localparam logic [3:0] PW_WRAP_ZERO  = 4'h5;
   localparam logic [3:0] PW_WRAP_RANGE = 4'h6;
   localparam logic [3:0] PW_WRAP_RATIO = 4'h7;
   localparam logic [3:0] PW_WRAP_OFFS  = 4'h8;

   // Values after reset and accepted ranges.
   localparam logic [31:0] POSITION_RST     = 32'h0000_0000;
   localparam logic [15:0] GEAR_DEFAULT     = 16'h0001;
   localparam logic [15:0] GEAR_MIN         = 16'h0001;
   localparam logic [1:0]  DIR_DEFAULT      = 2'h1;
   localparam logic [1:0]  DIR_MAX          = 2'h3;
   localparam int          DIR_CW_BIT       = 0;
   localparam int          DIR_DRIVER_BIT   = 1;
   localparam logic [15:0] GEAR_RATIO_OFF   = 16'h0000;
   localparam logic [15:0] GEAR_RATIO_ONE   = 16'h0064;
   localparam logic [15:0] GEAR_RATIO_MAX   = 16'h7fff;
   localparam logic        WRAP_EN_DEFAULT  = 1'b1;
   localparam logic [15:0] WRAP_ZERO_DEF    = 16'h0001;
   localparam logic [15:0] WRAP_RANGE_DEF   = 16'h000a;
   localparam logic [15:0] WRAP_RATIO_DEF   = 16'h1388;
   localparam logic [15:0] WRAP_RATIO_MAX   = 16'h2710;
   localparam logic [31:0] WRAP_OFFS_DEF    = 32'h0000_0000;
   localparam logic [31:0] WRAP_OFFS_MIN    = 32'he000_0000;
   localparam logic [31:0] WRAP_OFFS_MAX    = 32'h1fff_ffff;

endpackage
`default_nettype wire

// ---- preset_edge_detect.sv ----
`default_nettype none
module preset_edge_detect (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // Sampled input
   input  wire logic sig_in,
   // Registered level and edges
   output var  logic level_q,
   output wire logic rise,
   output wire logic fall
);

   logic prev_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         level_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         level_q <= sig_in;
         prev_q  <= level_q;
      end
   end

   // Both edges come from registered samples, so each lasts one cycle.
   assign rise = level_q & ~prev_q;
   assign fall = ~level_q & prev_q;

endmodule
`default_nettype wire

// ---- setting_select.sv ----
`default_nettype none
module setting_select #(
   parameter int           W       = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // Source choice and values
   input  wire logic         manual_sel,
   input  wire logic [W-1:0] sensor_val,
   input  wire logic [W-1:0] manual_val,
   // Registered effective value
   output var  logic [W-1:0] eff_q
);

   wire logic [W-1:0] eff_d;

   assign eff_d = manual_sel ? manual_val : sensor_val;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         eff_q <= RST_VAL;
      end else begin
         eff_q <= eff_d;
      end
   end

endmodule
`default_nettype wire

// ---- home_coordinate_select.sv ----
`default_nettype none
module home_coordinate_select
   import home_coord_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Electrical preset and positions
   input  wire logic        electrical_preset_input,
   input  wire logic [31:0] command_position,
   input  wire logic [31:0] preset_position,
   // Coordinate events
   input  wire logic        preset_done,
   input  wire logic        homing_active,
   input  wire logic        preset_clear,
   input  wire logic        resolution_change,
   input  wire logic        high_speed_homing_req,
   // Source selectors
   input  wire logic        mech_settings_sel,
   input  wire logic        coord_wrap_sel,
   input  wire logic        mech_limit_sel,
   input  wire logic        mech_protect_sel,
   input  wire logic        jog_home_sel,
   // Manual parameter write
   input  wire logic        param_wr,
   input  wire logic [3:0]  param_code,
   input  wire logic [31:0] param_data,
   // Sensor stored values
   input  wire logic [15:0] sensor_gear_den,
   input  wire logic [15:0] sensor_gear_num,
   input  wire logic [1:0]  sensor_direction,
   input  wire logic [15:0] sensor_gear_ratio,
   input  wire logic        sensor_wrap_enable,
   input  wire logic [15:0] sensor_wrap_zero_count,
   input  wire logic [15:0] sensor_wrap_range,
   input  wire logic [15:0] sensor_wrap_ratio,
   input  wire logic [31:0] sensor_wrap_offset,
   // Home and coordinate status
   output var  logic        electrical_home_monitor,
   output var  logic        coordinate_valid_output,
   output var  logic [31:0] coordinate_position,
   output var  logic [31:0] home_reference,
   output var  logic        mech_home_commit,
   output var  logic [31:0] mech_home_value,
   // Homing request answer
   output var  logic        high_speed_homing,
   output var  logic        high_speed_homing_reject,
   // Write answer
   output var  logic        param_ack,
   output var  logic        param_reject,
   // Effective mechanism values
   output var  logic [15:0] gear_den,
   output var  logic [15:0] gear_num,
   output var  logic [1:0]  motor_direction_code,
   output var  logic        positive_cw,
   output var  logic [15:0] gear_ratio_hundredths,
   // Effective wrap values
   output var  logic        wrap_enable,
   output var  logic [15:0] wrap_zero_point_output,
   output var  logic [15:0] wrap_range,
   output var  logic [15:0] wrap_ratio,
   output var  logic [31:0] wrap_offset,
   // Protection and operation sources
   output var  logic        limit_apply,
   output var  logic        protect_apply,
   output var  logic        jog_home_manual
);

   // Accepts a manual write only when its value lies in the legal range.
   function automatic logic code_ok(input logic [3:0] code, input logic [31:0] d, input logic wrap_man);
      logic ok;
      ok = 1'b0;
      case (code)
         PW_GEAR_DEN, PW_GEAR_NUM: ok = (d[31:16] == 16'h0000) && (d[15:0] >= GEAR_MIN);
         PW_DIRECTION:             ok = (d <= {30'h0, DIR_MAX});
         PW_GEAR_RATIO:            ok = (d <= {16'h0, GEAR_RATIO_MAX});
         PW_WRAP_EN:               ok = wrap_man && (d[31:1] == 31'h0);
         PW_WRAP_ZERO, PW_WRAP_RANGE: ok = wrap_man && (d[31:16] == 16'h0000);
         PW_WRAP_RATIO:            ok = wrap_man && (d <= {16'h0, WRAP_RATIO_MAX});
         PW_WRAP_OFFS:             ok = wrap_man && ($signed(d) >= $signed(WRAP_OFFS_MIN))
                                         && ($signed(d) <= $signed(WRAP_OFFS_MAX));
         default:                  ok = 1'b0;
      endcase
      return ok;
   endfunction

   mech_st_t    st_q;
   mech_st_t    st_d;
   logic        el_level_q;
   logic [31:0] el_home_q;
   logic [31:0] mech_home_q;
   logic        preset_nonzero_q;
   logic [15:0] man_gear_den_q;
   logic [15:0] man_gear_num_q;
   logic [1:0]  man_dir_q;
   logic [15:0] man_gear_ratio_q;
   logic        man_wrap_en_q;
   logic [15:0] man_wrap_zero_q;
   logic [15:0] man_wrap_range_q;
   logic [15:0] man_wrap_ratio_q;
   logic [31:0] man_wrap_offs_q;
   logic [15:0] gear_ratio_raw;

   wire logic el_rise;
   wire logic el_fall;
   wire logic accept;
   wire logic wrap_code;
   wire logic dir_sel;
   wire logic unset_evt;
   wire logic [31:0] ref_home;
   wire logic [31:0] next_ratio;

   // Electrical preset sampling and edges.
   preset_edge_detect u_edge (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .sig_in  (electrical_preset_input),
      .level_q (el_level_q),
      .rise    (el_rise),
      .fall    (el_fall)
   );

   assign accept    = param_wr && code_ok(param_code, param_data, coord_wrap_sel == SEL_MANUAL);
   assign wrap_code = (param_code >= PW_WRAP_EN) && (param_code <= PW_WRAP_OFFS);
   // Coordinates follow the electrical home while it is held, the mechanical home otherwise.
   assign ref_home  = electrical_home_monitor ? el_home_q : mech_home_q;
   // A resolution change only loses the coordinate after a nonzero preset.
   assign unset_evt = preset_clear || (resolution_change && preset_nonzero_q);
   // Codes 2 and 3 take the driver direction even in sensor mode.
   assign dir_sel   = (mech_settings_sel == SEL_MANUAL) || man_dir_q[DIR_DRIVER_BIT];
   // Zero disables the ratio, which then counts as one.
   assign next_ratio = {16'h0, (gear_ratio_raw == GEAR_RATIO_OFF) ? GEAR_RATIO_ONE : gear_ratio_raw};

   // Mechanical coordinate state; completion wins over a clear in the same cycle.
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         MS_UNSET:  if (homing_active) st_d = MS_HOMING;
                    else if (preset_done) st_d = MS_SET;
         MS_SET:    if (homing_active) st_d = MS_HOMING;
                    else if (!preset_done && unset_evt) st_d = MS_UNSET;
         MS_HOMING: if (preset_done) st_d = MS_SET;
                    else if (!homing_active) st_d = MS_UNSET;
         default:   st_d = MS_UNSET;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q                    <= MS_UNSET;
         coordinate_valid_output <= 1'b0;
      end else begin
         st_q                    <= st_d;
         coordinate_valid_output <= (st_d == MS_SET);
      end
   end

   // Electrical home: captured on the rising edge, held only in this register.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         electrical_home_monitor <= 1'b0;
         el_home_q               <= POSITION_RST;
      end else begin
         if (el_rise) begin
            electrical_home_monitor <= 1'b1;
            el_home_q               <= command_position;
         end else if (el_fall) begin
            electrical_home_monitor <= 1'b0;
         end else if (preset_done && electrical_home_monitor) begin
            el_home_q <= preset_position;
         end
      end
   end

   // Mechanical home; only this value is ever handed out for commit.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mech_home_q      <= POSITION_RST;
         preset_nonzero_q <= 1'b0;
         mech_home_commit <= 1'b0;
         mech_home_value  <= POSITION_RST;
      end else begin
         mech_home_commit <= preset_done;
         if (preset_done) begin
            mech_home_q      <= preset_position;
            mech_home_value  <= preset_position;
            preset_nonzero_q <= (preset_position != POSITION_RST);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         home_reference      <= POSITION_RST;
         coordinate_position <= POSITION_RST;
      end else begin
         home_reference      <= ref_home;
         coordinate_position <= command_position - ref_home;
      end
   end

   // High-speed homing needs a set coordinate and no electrical home.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         high_speed_homing        <= 1'b0;
         high_speed_homing_reject <= 1'b0;
      end else begin
         high_speed_homing        <= high_speed_homing_req && !electrical_home_monitor && (st_q == MS_SET);
         high_speed_homing_reject <= high_speed_homing_req && (electrical_home_monitor || (st_q != MS_SET));
      end
   end

   // Manual parameter store; out-of-range and sensor-mode wrap writes are refused.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         param_ack        <= 1'b0;
         param_reject     <= 1'b0;
         man_gear_den_q   <= GEAR_DEFAULT;
         man_gear_num_q   <= GEAR_DEFAULT;
         man_dir_q        <= DIR_DEFAULT;
         man_gear_ratio_q <= GEAR_RATIO_OFF;
         man_wrap_en_q    <= WRAP_EN_DEFAULT;
         man_wrap_zero_q  <= WRAP_ZERO_DEF;
         man_wrap_range_q <= WRAP_RANGE_DEF;
         man_wrap_ratio_q <= WRAP_RATIO_DEF;
         man_wrap_offs_q  <= WRAP_OFFS_DEF;
      end else begin
         param_ack    <= accept;
         param_reject <= param_wr && !accept;
         if (accept) begin
            unique case (param_code)
               PW_GEAR_DEN:   man_gear_den_q   <= param_data[15:0];
               PW_GEAR_NUM:   man_gear_num_q   <= param_data[15:0];
               PW_DIRECTION:  man_dir_q        <= param_data[1:0];
               PW_GEAR_RATIO: man_gear_ratio_q <= param_data[15:0];
               PW_WRAP_EN:    man_wrap_en_q    <= param_data[0];
               PW_WRAP_ZERO:  man_wrap_zero_q  <= param_data[15:0];
               PW_WRAP_RANGE: man_wrap_range_q <= param_data[15:0];
               PW_WRAP_RATIO: man_wrap_ratio_q <= param_data[15:0];
               PW_WRAP_OFFS:  man_wrap_offs_q  <= param_data;
            endcase
         end
      end
   end

   // Mechanism values follow the mechanism selector; direction also takes the manual value when it holds code 2 or 3.
   setting_select #(.W(16), .RST_VAL(GEAR_DEFAULT)) u_gear_den (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(mech_settings_sel),
      .sensor_val(sensor_gear_den), .manual_val(man_gear_den_q), .eff_q(gear_den));
   setting_select #(.W(16), .RST_VAL(GEAR_DEFAULT)) u_gear_num (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(mech_settings_sel),
      .sensor_val(sensor_gear_num), .manual_val(man_gear_num_q), .eff_q(gear_num));
   setting_select #(.W(16), .RST_VAL(GEAR_RATIO_OFF)) u_gear_ratio (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(mech_settings_sel),
      .sensor_val(sensor_gear_ratio), .manual_val(man_gear_ratio_q), .eff_q(gear_ratio_raw));
   setting_select #(.W(2), .RST_VAL(DIR_DEFAULT)) u_dir (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(dir_sel),
      .sensor_val(sensor_direction), .manual_val(man_dir_q), .eff_q(motor_direction_code));

   // Wrap values follow the coordinate selector.
   setting_select #(.W(1), .RST_VAL(WRAP_EN_DEFAULT)) u_wrap_en (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(coord_wrap_sel),
      .sensor_val(sensor_wrap_enable), .manual_val(man_wrap_en_q), .eff_q(wrap_enable));
   setting_select #(.W(16), .RST_VAL(WRAP_ZERO_DEF)) u_wrap_zero (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(coord_wrap_sel),
      .sensor_val(sensor_wrap_zero_count), .manual_val(man_wrap_zero_q), .eff_q(wrap_zero_point_output));
   setting_select #(.W(16), .RST_VAL(WRAP_RANGE_DEF)) u_wrap_range (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(coord_wrap_sel),
      .sensor_val(sensor_wrap_range), .manual_val(man_wrap_range_q), .eff_q(wrap_range));
   setting_select #(.W(16), .RST_VAL(WRAP_RATIO_DEF)) u_wrap_ratio (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(coord_wrap_sel),
      .sensor_val(sensor_wrap_ratio), .manual_val(man_wrap_ratio_q), .eff_q(wrap_ratio));
   setting_select #(.W(32), .RST_VAL(WRAP_OFFS_DEF)) u_wrap_offs (
      .mclk(mclk), .rst_n(rst_n), .manual_sel(coord_wrap_sel),
      .sensor_val(sensor_wrap_offset), .manual_val(man_wrap_offs_q), .eff_q(wrap_offset));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         positive_cw           <= DIR_DEFAULT[DIR_CW_BIT];
         gear_ratio_hundredths <= GEAR_RATIO_ONE;
         limit_apply           <= 1'b1;
         protect_apply         <= 1'b1;
         jog_home_manual       <= 1'b0;
      end else begin
         positive_cw           <= motor_direction_code[DIR_CW_BIT];
         gear_ratio_hundredths <= next_ratio[15:0];
         limit_apply           <= (mech_limit_sel == SEL_SENSOR);
         protect_apply         <= (mech_protect_sel == SEL_SENSOR);
         jog_home_manual       <= (jog_home_sel == SEL_MANUAL);
      end
   end

   property p_el_capture;
      @(posedge mclk) disable iff (!rst_n) el_rise |=> (el_home_q == $past(command_position));
   endproperty
   a_el_capture: assert property (p_el_capture) else $error("electrical home not captured");

   property p_el_ref;
      @(posedge mclk) disable iff (!rst_n) electrical_home_monitor ##1 electrical_home_monitor
         |-> (home_reference == $past(el_home_q));
   endproperty
   a_el_ref: assert property (p_el_ref) else $error("reference is not electrical home");

   property p_el_release;
      @(posedge mclk) disable iff (!rst_n) el_fall
         |=> !electrical_home_monitor ##1 (home_reference == $past(mech_home_q));
   endproperty
   a_el_release: assert property (p_el_release) else $error("electrical home not released");

   property p_monitor;
      @(posedge mclk) disable iff (!rst_n) electrical_home_monitor |-> (el_level_q || el_fall || $past(el_level_q));
   endproperty
   a_monitor: assert property (p_monitor) else $error("monitor on without preset input");

   property p_commit;
      @(posedge mclk) disable iff (!rst_n) mech_home_commit
         |-> ($past(preset_done) && mech_home_value == $past(preset_position));
   endproperty
   a_commit: assert property (p_commit) else $error("commit not caused by preset");

   property p_both_homes;
      @(posedge mclk) disable iff (!rst_n) (preset_done && electrical_home_monitor && !el_rise && !el_fall)
         |=> (el_home_q == $past(preset_position)) && (mech_home_q == $past(preset_position));
   endproperty
   a_both_homes: assert property (p_both_homes) else $error("homes not loaded together");

   property p_hs_reject;
      @(posedge mclk) disable iff (!rst_n) (high_speed_homing_req && electrical_home_monitor)
         |=> high_speed_homing_reject && !high_speed_homing;
   endproperty
   a_hs_reject: assert property (p_hs_reject) else $error("high-speed homing not refused");

   property p_unset;
      @(posedge mclk) disable iff (!rst_n) ((homing_active || preset_clear) && !preset_done)
         |=> !coordinate_valid_output;
   endproperty
   a_unset: assert property (p_unset) else $error("coordinate still valid");

   property p_valid;
      @(posedge mclk) disable iff (!rst_n) (preset_done && !homing_active)
         |=> coordinate_valid_output ##1 (coordinate_valid_output || $past(homing_active || unset_evt));
   endproperty
   a_valid: assert property (p_valid) else $error("coordinate not valid after preset");

   property p_wrap_lock;
      @(posedge mclk) disable iff (!rst_n) (param_wr && wrap_code && coord_wrap_sel == SEL_SENSOR)
         |=> param_reject && $stable(man_wrap_offs_q) && $stable(man_wrap_range_q);
   endproperty
   a_wrap_lock: assert property (p_wrap_lock) else $error("wrap write accepted in sensor mode");

   property p_gear_zero;
      @(posedge mclk) disable iff (!rst_n) (param_wr && param_code == PW_GEAR_DEN && param_data == POSITION_RST)
         |=> param_reject && $stable(man_gear_den_q);
   endproperty
   a_gear_zero: assert property (p_gear_zero) else $error("zero gear accepted");

   property p_ratio;
      @(posedge mclk) disable iff (!rst_n) (gear_ratio_raw == GEAR_RATIO_OFF)
         |=> (gear_ratio_hundredths == GEAR_RATIO_ONE);
   endproperty
   a_ratio: assert property (p_ratio) else $error("disabled ratio not one");

endmodule
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model (
   // Clock
   input  wire logic        mclk,
   // Preset level and position driven by the host
   output var  logic        electrical_preset_input,
   output var  logic [31:0] command_position
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      electrical_preset_input = 1'b0;
      command_position        = 32'h0000_0000;
   end
   // Levels change only at a falling edge, well clear of the sampling edge.
   task automatic drive(input logic lvl, input logic [31:0] pos);
      @(negedge mclk);
      electrical_preset_input = lvl;
      command_position        = pos;
   endtask
endmodule
`default_nettype wire

// ---- home_coordinate_select_tb.sv ----
`default_nettype none
module home_coordinate_select_tb
   import home_coord_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0, rst_n = 1'b0, preset_done = 1'b0, homing_active = 1'b0, preset_clear = 1'b0;
   logic        resolution_change = 1'b0, high_speed_homing_req = 1'b0, param_wr = 1'b0, sensor_wrap_enable = 1'b1;
   logic        mech_settings_sel = 1'b0, coord_wrap_sel = 1'b0, mech_limit_sel = 1'b0, mech_protect_sel = 1'b0;
   logic        jog_home_sel = 1'b0, electrical_preset_input, ok;
   logic [3:0]  param_code = 4'h0;
   logic [1:0]  sensor_direction = 2'h1;
   logic [31:0] preset_position = 32'h0, param_data = 32'h0, sensor_wrap_offset = 32'h0, command_position, pos, d;
   logic [15:0] sensor_gear_den = 16'h1, sensor_gear_num = 16'h1, sensor_gear_ratio = 16'h0;
   logic [15:0] sensor_wrap_zero_count = 16'h1, sensor_wrap_range = 16'ha, sensor_wrap_ratio = 16'h1388;
   logic        electrical_home_monitor, coordinate_valid_output, mech_home_commit, high_speed_homing, wrap_enable;
   logic        high_speed_homing_reject, param_ack, param_reject, positive_cw, limit_apply;
   logic        protect_apply, jog_home_manual;
   logic [1:0]  motor_direction_code;
   logic [15:0] gear_den, gear_num, gear_ratio_hundredths, wrap_zero_point_output, wrap_range, wrap_ratio;
   logic [31:0] coordinate_position, home_reference, mech_home_value, wrap_offset;
   int          fails = 0, total_checks = 0;

   always #5 mclk = ~mclk;
   home_coordinate_select dut (.*);
   host_model host (.mclk(mclk), .electrical_preset_input(electrical_preset_input), .command_position(command_position));

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Returns while the one-cycle answer to the strobe still stands.
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   function automatic logic accept(input logic [3:0] c, input logic [31:0] v, input logic wsel);
      case (c)
         PW_GEAR_DEN, PW_GEAR_NUM: return v != 32'h0 && v <= 32'hffff;
         PW_DIRECTION: return v <= 32'h3;
         PW_GEAR_RATIO: return v <= 32'h7fff;
         PW_WRAP_EN: return wsel && v <= 32'h1;
         PW_WRAP_ZERO, PW_WRAP_RANGE: return wsel && v <= 32'hffff;
         PW_WRAP_RATIO: return wsel && v <= 32'h2710;
         PW_WRAP_OFFS: return wsel && $signed(v) >= $signed(32'he000_0000) && $signed(v) <= $signed(32'h1fff_ffff);
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic [15:0] ratio_of(input logic [15:0] raw);
      return (raw == 16'h0) ? 16'h0064 : raw;
   endfunction
   task automatic write(input logic [3:0] c, input logic [31:0] v);
      param_code = c;
      param_data = v;
      ok         = accept(c, v, coord_wrap_sel);
      pulse(param_wr);
      chk({param_ack, param_reject}, {ok, !ok});
      cyc(1);
   endtask
   task automatic hs(input logic exp);
      pulse(high_speed_homing_req);
      chk({high_speed_homing, high_speed_homing_reject}, {exp, !exp});
      cyc(1);
   endtask

   initial begin
      #50us;
      fails++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(90630));
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
      chk({gear_den, gear_num, gear_ratio_hundredths}, {16'h1, 16'h1, 16'h64});
      chk({motor_direction_code, positive_cw, limit_apply, protect_apply, jog_home_manual, coordinate_valid_output},
          7'h3c);
      $display("test reset finished");
      repeat (8) begin
         sensor_gear_den    = 16'($urandom) | 16'h1;
         sensor_gear_num    = 16'($urandom) | 16'h1;
         sensor_gear_ratio  = 16'($urandom % 32768);
         sensor_direction   = 2'($urandom);
         sensor_wrap_range  = 16'($urandom);
         sensor_wrap_offset = $urandom;
         {sensor_wrap_enable, sensor_wrap_zero_count, sensor_wrap_ratio} = 33'({$urandom, $urandom});
         {mech_limit_sel, mech_protect_sel, jog_home_sel} = 3'($urandom);
         cyc(3);
         chk({limit_apply, protect_apply, jog_home_manual},
             {!mech_limit_sel, !mech_protect_sel, jog_home_sel});
         chk({gear_den, gear_num, gear_ratio_hundredths},
             {sensor_gear_den, sensor_gear_num, ratio_of(sensor_gear_ratio)});
         chk({motor_direction_code, positive_cw, wrap_range},
             {sensor_direction, sensor_direction[0], sensor_wrap_range});
         chk({wrap_enable, wrap_zero_point_output, wrap_ratio, wrap_offset},
             {sensor_wrap_enable, sensor_wrap_zero_count, sensor_wrap_ratio, sensor_wrap_offset});
      end
      $display("test selectors finished");
      write(PW_GEAR_DEN, 32'h0);
      write(PW_GEAR_NUM, 32'h1_0000);
      write(PW_WRAP_RANGE, 32'h5);
      coord_wrap_sel    = 1'b1;
      mech_settings_sel = 1'b1;
      write(PW_WRAP_RANGE, 32'h5);
      write(PW_GEAR_RATIO, 32'h8000);
      write(PW_GEAR_RATIO, 32'h7fff);
      write(PW_GEAR_DEN, 32'hffff);
      cyc(1);
      chk({wrap_range, gear_ratio_hundredths, gear_den}, {16'h5, 16'h7fff, 16'hffff});
      repeat (12) begin
         d = $urandom >> ($urandom % 32);
         write(4'($urandom % 10), d);
      end
      write(PW_GEAR_RATIO, 32'h0);
      mech_settings_sel = 1'b0;
      write(PW_DIRECTION, 32'h3);
      cyc(2);
      chk({gear_ratio_hundredths, motor_direction_code, positive_cw, gear_den},
          {ratio_of(sensor_gear_ratio), 3'h7, sensor_gear_den});
      $display("test writes finished");
      hs(1'b0);
      preset_position = $urandom | 32'h8000_0000;
      pulse(preset_done);
      chk({coordinate_valid_output, mech_home_commit, mech_home_value}, {2'h3, preset_position});
      hs(1'b1);
      pos = $urandom;
      host.drive(1'b1, pos);
      cyc(4);
      chk({electrical_home_monitor, mech_home_commit, home_reference, coordinate_position},
          {2'h2, pos, 32'h0});
      host.drive(1'b1, pos + 32'h10);
      cyc(2);
      chk(coordinate_position, 32'h10);
      hs(1'b0);
      host.drive(1'b0, pos);
      cyc(4);
      chk({electrical_home_monitor, home_reference}, {1'b0, preset_position});
      host.drive(1'b1, pos);
      cyc(4);
      preset_position = $urandom | 32'h1;
      pulse(preset_done);
      cyc(1);
      chk({mech_home_value, home_reference, electrical_home_monitor}, {preset_position, preset_position, 1'b1});
      host.drive(1'b0, pos);
      $display("test electrical home finished");
      pulse(resolution_change);
      cyc(1);
      chk(coordinate_valid_output, 1'b0);
      pulse(preset_done);
      chk(coordinate_valid_output, 1'b1);
      pulse(preset_clear);
      cyc(1);
      chk(coordinate_valid_output, 1'b0);
      pulse(preset_done);
      homing_active = 1'b1;
      cyc(2);
      chk(coordinate_valid_output, 1'b0);
      hs(1'b0);
      homing_active = 1'b0;
      $display("test coordinate valid finished");
      tally_and_finish();
   end
endmodule
`default_nettype wire
